/* File: sfsr_cfg.svh */
// Constants for the serial flash status register block.
`ifndef SFSR_CFG_SVH
`define SFSR_CFG_SVH

// ****************************************************************
// Command opcodes
// ****************************************************************
`define SFSR_OP_READ_STATUS 8'h05
`define SFSR_OP_WRITE_ONE 8'h01
`define SFSR_OP_WRITE_TWO 8'h31
`define SFSR_OP_WRITE_EN 8'h06
`define SFSR_OP_WRITE_DIS 8'h04
`define SFSR_OP_ABORT 8'hF0
`define SFSR_ABORT_CONFIRM 8'hD0

// ****************************************************************
// Status byte one fields
// ****************************************************************
`define SFSR_B1_LOCK 7
`define SFSR_B1_FAIL 5
`define SFSR_B1_GUARD 4
`define SFSR_B1_SWP_HI 3
`define SFSR_B1_SWP_LO 2
`define SFSR_B1_WEL 1
`define SFSR_B1_BUSY 0
`define SFSR_GLOBAL_HI 5
`define SFSR_GLOBAL_LO 2

// ****************************************************************
// Status byte two fields
// ****************************************************************
`define SFSR_B2_ABORT_EN 4
`define SFSR_B2_LOCKDOWN_EN 3
`define SFSR_B2_PROG_PAUSED 2
`define SFSR_B2_ERASE_PAUSED 1
`define SFSR_B2_BUSY 0

// ****************************************************************
// Protection summary codes and counters
// ****************************************************************
`define SFSR_SWP_NONE 2'h0
`define SFSR_SWP_SOME 2'h1
`define SFSR_SWP_ALL 2'h3
`define SFSR_BIT_LAST 3'h7
`define SFSR_BIT_FIRST 3'h0

`endif

/* File: sfsr_pkg.sv */
// Types shared by the serial flash status register block.
`default_nettype none
package sfsr_pkg;

    // Phase of the serial command frame.
    typedef enum logic [2:0] {
        SFSR_OPCODE,
        SFSR_READ,
        SFSR_DATA,
        SFSR_CONFIRM,
        SFSR_EXTRA
    } sfsr_phase_t;

endpackage : sfsr_pkg
`default_nettype wire

/* File: sfsr_sync.sv */
// Two flip-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sfsr_sync #(
    parameter int WIDTH = 4
) (
    input wire logic i_clk_sys, // System clock.
    input wire logic i_arst_n, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] i_async, // Raw pin levels.
    input wire logic [WIDTH-1:0] i_reset_val, // Constant level held during reset.
    output logic [WIDTH-1:0] o_sync // Synchronised levels.
);

    logic [WIDTH-1:0] stage_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stage_q <= '0;
            sync_q <= '0;
        end else begin
            stage_q <= i_async ^ i_reset_val;
            sync_q <= stage_q;
        end
    end

    // Flipping by a constant lets idle-high pins read idle during reset.
    assign o_sync = sync_q ^ i_reset_val;

endmodule : sfsr_sync
`default_nettype wire

/* File: sfsr_top.sv */
// Status register bank of a serial flash, reached over its serial command pins.
//
// Notes on behaviour
// - Byte two bits 7 to 5 read zero.
// - Byte two bit 4 enables abort command.
// - Byte two bit 3 enables lockdown commands.
// - Byte two bit 2 shows program paused.
// - Byte two bit 1 shows erase paused.
// - Byte two bit 0 is busy flag.
// - Byte two write changes bits 4, 3 only.
// - Lock set blocks all sector protection changes.
// - Lock clear at power-up, abort keeps it.
// - Guard pin asserted: lock only 0 to 1.
// - Byte one write changes only lock bit.
// - Failed byte sets program fail flag.
// - Refused operations never set fail flag.
// - Read-only bit mirrors guard pin state.
// - Summary reports none, some, all protected.
// - Latch clear rejects all modifying commands.
// - Latch clear after power-up and reset.
// - Latch clears when modifying operations end.
// - Partial opcode abort keeps latch set.
// - Abort ignored unless enabled; enable persistent.
// - Lockdown ignored unless enabled; enable persistent.
// - Freeze holds lockdown enable at zero.
// - Read opcode streams both bytes repeatedly.
// - Summary codes 00, 01, 11; 10 unused.
// - Byte one write is opcode plus byte.
// - Byte two write is opcode plus byte.
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_cfg.svh"
module sfsr_top (
    input wire logic i_clk_sys, // System clock, 100 MHz.
    input wire logic i_arst_n, // Asynchronous reset, active low; acts as power-up.
    input wire logic i_sck, // Serial clock pin.
    input wire logic i_cs_n, // Chip select pin, active low.
    input wire logic i_si, // Serial data in pin.
    output logic o_so, // Serial data out pin.
    output logic o_so_oe, // Serial data out enable, high while driving.
    input wire logic i_guard_n, // Write-guard pin, active low.
    input wire logic i_busy, // Core runs an internal operation.
    input wire logic i_prog_paused, // Core holds a program-suspended sector.
    input wire logic i_erase_paused, // Core holds an erase-suspended sector.
    input wire logic i_any_protected, // At least one sector is protected.
    input wire logic i_all_protected, // Every sector is protected.
    input wire logic i_op_done, // Pulse: program or erase finished.
    input wire logic i_op_fail, // With i_op_done: a byte failed.
    input wire logic i_op_refused, // With i_op_done: refused, not failed.
    input wire logic i_latch_op_end, // Pulse: modifying operation ended or aborted.
    input wire logic i_hold_abort, // Pulse: a hold condition aborted.
    input wire logic i_freeze_done, // Pulse: freeze-lockdown executed.
    output logic o_write_latch, // Write latch, lets modifying commands run.
    output logic o_protection_lock, // Protection lock bit.
    output logic o_sector_cmd_allowed, // Sector protect changes may run.
    output logic o_lockdown_allowed, // Lockdown and freeze commands may run.
    output logic o_abort_enable, // Abort command enable bit.
    output logic o_abort_pulse, // Pulse: accepted abort command.
    output logic o_global_pulse, // Pulse: global protect request.
    output logic [3:0] o_global_code // Global protect request code.
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************

    logic sck_s;
    logic cs_n_s;
    logic si_s;
    logic guard_n_s;

    // All four pins come from outside the clock domain.
    sfsr_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_async({i_sck, i_cs_n, i_si, i_guard_n}),
        .i_reset_val(4'h5),
        .o_sync({sck_s, cs_n_s, si_s, guard_n_s})
    );

    // ****************************************************************
    // Status byte assembly
    // ****************************************************************

    logic lock_q, lock_d;
    logic fail_q, fail_d;
    logic wel_q, wel_d;
    logic abort_en_q, abort_en_d;
    logic lockdown_en_q, lockdown_en_d;
    logic frozen_q, frozen_d;
    logic abort_pulse_q, abort_pulse_d;
    logic global_pulse_q, global_pulse_d;
    logic [3:0] global_code_q, global_code_d;

    // Builds byte one (sel low) or byte two (sel high) from live state.
    function automatic logic [7:0] status_byte(input logic sel);
        logic [7:0] b;
        b = 8'h00;
        if (!sel) begin
            b[`SFSR_B1_LOCK] = lock_q;
            b[`SFSR_B1_FAIL] = fail_q;
            b[`SFSR_B1_GUARD] = guard_n_s;
            if (i_all_protected) begin
                b[`SFSR_B1_SWP_HI:`SFSR_B1_SWP_LO] = `SFSR_SWP_ALL;
            end else if (i_any_protected) begin
                b[`SFSR_B1_SWP_HI:`SFSR_B1_SWP_LO] = `SFSR_SWP_SOME;
            end else begin
                b[`SFSR_B1_SWP_HI:`SFSR_B1_SWP_LO] = `SFSR_SWP_NONE;
            end
            b[`SFSR_B1_WEL] = wel_q;
            b[`SFSR_B1_BUSY] = i_busy;
        end else begin
            // Bits 7 to 5 stay zero.
            b[`SFSR_B2_ABORT_EN] = abort_en_q;
            b[`SFSR_B2_LOCKDOWN_EN] = lockdown_en_q;
            b[`SFSR_B2_PROG_PAUSED] = i_prog_paused;
            b[`SFSR_B2_ERASE_PAUSED] = i_erase_paused;
            b[`SFSR_B2_BUSY] = i_busy;
        end
        return b;
    endfunction : status_byte

    // ****************************************************************
    // Serial frame engine
    // ****************************************************************

    sfsr_pkg::sfsr_phase_t phase_q, phase_d;
    logic sck_prev_q, sck_prev_d;
    logic cs_prev_q, cs_prev_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] opcode_q, opcode_d;
    logic [7:0] data_q, data_d;
    logic opcode_ok_q, opcode_ok_d;
    logic data_ok_q, data_ok_d;
    logic confirm_ok_q, confirm_ok_d;
    logic [7:0] tx_q, tx_d;
    logic [2:0] tx_cnt_q, tx_cnt_d;
    logic tx_sel_q, tx_sel_d;
    logic so_q, so_d;
    logic so_oe_q, so_oe_d;

    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    logic [7:0] byte_in;
    logic [7:0] tx_byte;

    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;
    assign frame_end = cs_n_s & ~cs_prev_q;
    assign byte_in = {shift_q[6:0], si_s};

    // Samples input bits on rising edges, drives output on falling edges.
    always_comb begin
        phase_d = phase_q;
        sck_prev_d = sck_s;
        cs_prev_d = cs_n_s;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        opcode_d = opcode_q;
        data_d = data_q;
        opcode_ok_d = opcode_ok_q;
        data_ok_d = data_ok_q;
        confirm_ok_d = confirm_ok_q;
        tx_d = tx_q;
        tx_cnt_d = tx_cnt_q;
        tx_sel_d = tx_sel_q;
        so_d = so_q;
        tx_byte = status_byte(tx_sel_q);
        if (cs_n_s) begin
            // Idle: the frame flags were read by the status logic this cycle.
            phase_d = sfsr_pkg::SFSR_OPCODE;
            bit_cnt_d = `SFSR_BIT_FIRST;
            opcode_ok_d = 1'b0;
            data_ok_d = 1'b0;
            confirm_ok_d = 1'b0;
            tx_cnt_d = `SFSR_BIT_FIRST;
            tx_sel_d = 1'b0;
        end else begin
            if (sck_rise) begin
                shift_d = byte_in;
                bit_cnt_d = bit_cnt_q + 3'h1;
                if (bit_cnt_q == `SFSR_BIT_LAST) begin
                    case (phase_q)
                        sfsr_pkg::SFSR_OPCODE: begin
                            opcode_d = byte_in;
                            opcode_ok_d = 1'b1;
                            if (byte_in == `SFSR_OP_READ_STATUS) begin
                                phase_d = sfsr_pkg::SFSR_READ;
                            end else if (byte_in == `SFSR_OP_WRITE_ONE ||
                                         byte_in == `SFSR_OP_WRITE_TWO) begin
                                phase_d = sfsr_pkg::SFSR_DATA;
                            end else if (byte_in == `SFSR_OP_ABORT) begin
                                phase_d = sfsr_pkg::SFSR_CONFIRM;
                            end else begin
                                phase_d = sfsr_pkg::SFSR_EXTRA;
                            end
                        end
                        sfsr_pkg::SFSR_DATA: begin
                            data_d = byte_in;
                            data_ok_d = 1'b1;
                            phase_d = sfsr_pkg::SFSR_EXTRA;
                        end
                        sfsr_pkg::SFSR_CONFIRM: begin
                            confirm_ok_d = (byte_in == `SFSR_ABORT_CONFIRM);
                            phase_d = sfsr_pkg::SFSR_EXTRA;
                        end
                        sfsr_pkg::SFSR_READ: begin
                            phase_d = sfsr_pkg::SFSR_READ;
                        end
                        default: begin
                            phase_d = sfsr_pkg::SFSR_EXTRA;
                        end
                    endcase
                end
            end
            // Each falling edge presents the next bit, byte one then two.
            if (sck_fall && phase_q == sfsr_pkg::SFSR_READ) begin
                if (tx_cnt_q == `SFSR_BIT_FIRST) begin
                    so_d = tx_byte[7];
                    tx_d = {tx_byte[6:0], 1'b0};
                end else begin
                    so_d = tx_q[7];
                    tx_d = {tx_q[6:0], 1'b0};
                end
                tx_cnt_d = tx_cnt_q + 3'h1;
                if (tx_cnt_q == `SFSR_BIT_LAST) begin
                    tx_sel_d = ~tx_sel_q;
                end
            end
        end
        so_oe_d = ~cs_n_s && phase_d == sfsr_pkg::SFSR_READ;
    end

    // Registers the frame engine.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_q <= sfsr_pkg::SFSR_OPCODE;
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            bit_cnt_q <= `SFSR_BIT_FIRST;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            data_q <= 8'h00;
            opcode_ok_q <= 1'b0;
            data_ok_q <= 1'b0;
            confirm_ok_q <= 1'b0;
            tx_q <= 8'h00;
            tx_cnt_q <= `SFSR_BIT_FIRST;
            tx_sel_q <= 1'b0;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            sck_prev_q <= sck_prev_d;
            cs_prev_q <= cs_prev_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            opcode_q <= opcode_d;
            data_q <= data_d;
            opcode_ok_q <= opcode_ok_d;
            data_ok_q <= data_ok_d;
            confirm_ok_q <= confirm_ok_d;
            tx_q <= tx_d;
            tx_cnt_q <= tx_cnt_d;
            tx_sel_q <= tx_sel_d;
            so_q <= so_d;
            so_oe_q <= so_oe_d;
        end
    end

    // ****************************************************************
    // Status bit update
    // ****************************************************************

    logic on_boundary;
    logic is_write_cmd;
    logic write_commit;

    assign on_boundary = (bit_cnt_q == `SFSR_BIT_FIRST);
    // A partial opcode never counts as a write command.
    assign is_write_cmd = opcode_ok_q &&
                          (opcode_q == `SFSR_OP_WRITE_ONE || opcode_q == `SFSR_OP_WRITE_TWO);
    assign write_commit = frame_end && is_write_cmd && data_ok_q && on_boundary && wel_q;

    // Applies command results at frame end and core events; write enable wins over latch clears, freeze clear wins over lockdown enable set.
    always_comb begin
        lock_d = lock_q;
        fail_d = fail_q;
        wel_d = wel_q;
        abort_en_d = abort_en_q;
        lockdown_en_d = lockdown_en_q;
        frozen_d = frozen_q;
        abort_pulse_d = 1'b0;
        global_pulse_d = 1'b0;
        global_code_d = global_code_q;
        // A program or erase refused by protection or pausing leaves no error.
        if (i_op_done) begin
            fail_d = i_op_fail && !i_op_refused;
        end
        // Modifying operations and hold aborts drop the latch.
        if (i_latch_op_end || i_hold_abort) begin
            wel_d = 1'b0;
        end
        // Full write opcode seen: the latch drops whether it commits or aborts.
        if (frame_end && is_write_cmd) begin
            wel_d = 1'b0;
        end
        if (write_commit && opcode_q == `SFSR_OP_WRITE_ONE) begin
            // Only the lock bit of byte one is writable.
            if (!(guard_n_s == 1'b0 && lock_q && !data_q[`SFSR_B1_LOCK])) begin
                lock_d = data_q[`SFSR_B1_LOCK];
                global_pulse_d = !lock_q;
                global_code_d = data_q[`SFSR_GLOBAL_HI:`SFSR_GLOBAL_LO];
            end
        end
        if (write_commit && opcode_q == `SFSR_OP_WRITE_TWO) begin
            abort_en_d = data_q[`SFSR_B2_ABORT_EN];
            if (!frozen_q) begin
                lockdown_en_d = data_q[`SFSR_B2_LOCKDOWN_EN];
            end
        end
        if (frame_end && on_boundary && opcode_ok_q && opcode_q == `SFSR_OP_WRITE_DIS) begin
            wel_d = 1'b0;
        end
        // Abort keeps lock and enables; only the latch drops.
        if (frame_end && on_boundary && confirm_ok_q && opcode_q == `SFSR_OP_ABORT &&
            abort_en_q) begin
            abort_pulse_d = 1'b1;
            wel_d = 1'b0;
        end
        if (i_freeze_done) begin
            frozen_d = 1'b1;
        end
        if (frozen_q || i_freeze_done) begin
            lockdown_en_d = 1'b0;
        end
        // Write enable is applied last so that it wins.
        if (frame_end && on_boundary && opcode_ok_q && opcode_q == `SFSR_OP_WRITE_EN) begin
            wel_d = 1'b1;
        end
    end

    // Registers the status bits; reset stands in for power-up.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lock_q <= 1'b0;
            fail_q <= 1'b0;
            wel_q <= 1'b0;
            abort_en_q <= 1'b0;
            lockdown_en_q <= 1'b0;
            frozen_q <= 1'b0;
            abort_pulse_q <= 1'b0;
            global_pulse_q <= 1'b0;
            global_code_q <= 4'h0;
        end else begin
            lock_q <= lock_d;
            fail_q <= fail_d;
            wel_q <= wel_d;
            abort_en_q <= abort_en_d;
            lockdown_en_q <= lockdown_en_d;
            frozen_q <= frozen_d;
            abort_pulse_q <= abort_pulse_d;
            global_pulse_q <= global_pulse_d;
            global_code_q <= global_code_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Permissions handed to the command core.
    assign o_so = so_q;
    assign o_so_oe = so_oe_q;
    assign o_write_latch = wel_q;
    assign o_protection_lock = lock_q;
    assign o_sector_cmd_allowed = ~lock_q & wel_q;
    assign o_lockdown_allowed = lockdown_en_q & wel_q;
    assign o_abort_enable = abort_en_q;
    assign o_abort_pulse = abort_pulse_q;
    assign o_global_pulse = global_pulse_q;
    assign o_global_code = global_code_q;

endmodule : sfsr_top
`default_nettype wire

/* File: sfsr_monitor.sv */
// Concurrent checks on the ports of the status register block.
`timescale 1ns/1ps
`default_nettype none
module sfsr_monitor (
    input wire logic i_clk_sys, // Clock.
    input wire logic i_arst_n, // Reset, active low.
    input wire logic i_cs_n, // Chip select.
    input wire logic i_guard_n, // Guard pin.
    input wire logic i_latch_op_end, // Operation end.
    input wire logic i_hold_abort, // Hold abort.
    input wire logic i_freeze_done, // Freeze done.
    input wire logic o_so_oe, // Output enable.
    input wire logic o_write_latch, // Write latch.
    input wire logic o_protection_lock, // Lock bit.
    input wire logic o_sector_cmd_allowed, // Sector grant.
    input wire logic o_lockdown_allowed, // Lockdown grant.
    input wire logic o_abort_enable, // Abort enable.
    input wire logic o_abort_pulse, // Abort pulse.
    input wire logic o_global_pulse // Global pulse.
);
    logic [3:0] idle_q;
    logic [3:0] idle_d;
    // Counts idle cycles so that frame commits have settled before a clear is judged.
    always_comb begin
        idle_d = 4'h0;
        if (i_cs_n) begin
            idle_d = (idle_q == 4'hF) ? idle_q : idle_q + 4'h1;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            idle_q <= 4'h0;
        end else begin
            idle_q <= idle_d;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    a_sector_grant: assert property (o_sector_cmd_allowed == (!o_protection_lock && o_write_latch))
        else $error("sector grant wrong");
    a_lockdown_grant: assert property (o_lockdown_allowed |-> o_write_latch)
        else $error("lockdown grant without latch");
    a_latch_clear: assert property ((i_latch_op_end || i_hold_abort) && idle_q > 4'h8 |=> !o_write_latch)
        else $error("latch not cleared");
    a_freeze_hold: assert property (i_freeze_done |=> !o_lockdown_allowed [*8])
        else $error("lockdown after freeze");
    a_lock_guard: assert property ($fell(o_protection_lock) |-> $past(i_guard_n, 3))
        else $error("lock cleared while guarded");
    a_oe_idle: assert property (i_cs_n [*6] |-> !o_so_oe)
        else $error("output driven while idle");
    a_abort_gate: assert property (o_abort_pulse |-> o_abort_enable)
        else $error("abort while disabled");
    a_abort_keep: assert property (o_abort_pulse |=> $stable(o_abort_enable) [*3])
        else $error("abort changed enable");
    a_lock_abort: assert property (o_abort_pulse |=> $stable(o_protection_lock))
        else $error("abort changed lock");
    a_global_prior: assert property (o_global_pulse |-> !$past(o_protection_lock))
        else $error("global while locked");
    c_abort: cover property (o_abort_pulse);
    c_global: cover property (o_global_pulse);
    c_unlock: cover property ($fell(o_protection_lock));
endmodule : sfsr_monitor
bind sfsr_top sfsr_monitor u_sfsr_monitor (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_cs_n(i_cs_n), .i_guard_n(i_guard_n), .i_latch_op_end(i_latch_op_end),
    .i_hold_abort(i_hold_abort), .i_freeze_done(i_freeze_done), .o_so_oe(o_so_oe),
    .o_write_latch(o_write_latch), .o_protection_lock(o_protection_lock),
    .o_sector_cmd_allowed(o_sector_cmd_allowed), .o_lockdown_allowed(o_lockdown_allowed),
    .o_abort_enable(o_abort_enable), .o_abort_pulse(o_abort_pulse),
    .o_global_pulse(o_global_pulse));
`default_nettype wire

/* File: sfsr_host.sv */
// Serial host model that clocks command frames into the block.
`timescale 1ns/1ps
`default_nettype none
module sfsr_host (
    output logic o_sck, // Serial clock, low outside frames.
    output logic o_cs_n, // Chip select, active low.
    output logic o_si, // Serial data to the block.
    input wire logic i_so, // Serial data from the block.
    input wire logic i_so_oe // High while the block drives i_so.
);
    // Idle levels at time zero.
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Sends n bits MSB first and gathers the reply; a released line reads low.
    task xfer(input int n, input logic [39:0] tx, output logic [39:0] rx);
        rx = '0;
        #3 o_cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            o_si <= tx[39-i];
            #62.5 o_sck <= 1'b1;
            rx = {rx[38:0], i_so & i_so_oe};
            #62.5 o_sck <= 1'b0;
        end
        #62.5 o_cs_n <= 1'b1;
        o_si <= ~o_si;
        #300;
    endtask : xfer
endmodule : sfsr_host
`default_nettype wire

/* File: serial_flash_status_register_tb_top.sv */
// Self-checking bench for the status register block.
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_cfg.svh"
module serial_flash_status_register_tb_top;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_guard_n = 1'b1;
    logic [4:0] lv = 5'h00;
    logic [5:0] pul = 6'h00;
    logic [3:0] gc = 4'h0;
    logic [3:0] eg = 4'h0;
    int lk, fl, wl, ae, le, fz, nab, eab, bad_count, n_compared, cyc;
    wire logic sck, cs_n, si, so, so_oe, o_write_latch, o_protection_lock;
    wire logic o_abort_enable, o_abort_pulse, o_global_pulse, sca, lda;
    wire logic [3:0] o_global_code;
    sfsr_host u_sfsr_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
    sfsr_top u_sfsr_top (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_sck(sck),
        .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_guard_n(i_guard_n),
        .i_busy(lv[4]), .i_prog_paused(lv[3]), .i_erase_paused(lv[2]),
        .i_any_protected(lv[1]), .i_all_protected(lv[0]), .i_op_done(pul[5]),
        .i_op_fail(pul[4]), .i_op_refused(pul[3]), .i_latch_op_end(pul[2]),
        .i_hold_abort(pul[1]), .i_freeze_done(pul[0]), .o_write_latch(o_write_latch),
        .o_protection_lock(o_protection_lock), .o_sector_cmd_allowed(sca),
        .o_lockdown_allowed(lda), .o_abort_enable(o_abort_enable),
        .o_abort_pulse(o_abort_pulse), .o_global_pulse(o_global_pulse),
        .o_global_code(o_global_code));
    // Clock, hang limit and capture of event pulses.
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (o_abort_pulse === 1'b1) nab++;
        if (o_global_pulse === 1'b1) gc <= o_global_code;
        if (cyc == 80000) begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    end
    task finish_test;
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Expected first status byte from the model and the live core levels.
    function automatic logic [7:0] b1();
        return {lk[0], 1'b0, fl[0], i_guard_n, lv[0] ? 2'h3 : {1'b0, lv[1]}, wl[0], lv[4]};
    endfunction : b1
    // Reads the status stream and compares it and the outputs with the model.
    task sync;
        logic [39:0] rx;
        u_sfsr_host.xfer(40, {`SFSR_OP_READ_STATUS, 32'h0}, rx);
        chk(rx[31:24], b1());
        chk(rx[23:16], {3'h0, ae[0], le[0], lv[3:2], lv[4]});
        chk(rx[15:8], b1());
        chk({5'h0, o_write_latch, o_protection_lock, o_abort_enable},
            {5'h0, wl[0], lk[0], ae[0]});
        chk({6'h0, sca, lda}, {6'h0, !lk[0] & wl[0], le[0] & wl[0]});
        chk({nab[3:0], gc}, {eab[3:0], eg});
    endtask : sync
    // Sends one frame, then steps the model the way the block must.
    task fr(input int n, input logic [23:0] v);
        logic [39:0] rx;
        logic [7:0] op;
        logic [7:0] d;
        op = v[23:16];
        d = v[15:8];
        u_sfsr_host.xfer(n, {v, 16'h0}, rx);
        if (n >= 8 && n % 8 == 0 && op == `SFSR_OP_WRITE_EN) wl = 1;
        if (n >= 8 && n % 8 == 0 && op == `SFSR_OP_WRITE_DIS) wl = 0;
        if ((op == `SFSR_OP_WRITE_ONE || op == `SFSR_OP_WRITE_TWO) && n >= 8 && wl) begin
            if (n >= 16 && n % 8 == 0) begin
                if (op == `SFSR_OP_WRITE_TWO) begin
                    ae = d[4];
                    if (!fz) le = d[3];
                end else if (i_guard_n || !lk || d[7]) begin
                    if (!lk) eg = d[5:2];
                    lk = d[7];
                end
            end
            wl = 0;
        end
        if (op == `SFSR_OP_ABORT && n >= 16 && n % 8 == 0 && d == `SFSR_ABORT_CONFIRM && ae) begin
            eab++;
            wl = 0;
        end
        sync();
    endtask : fr
    // Pulses core events for one cycle.
    task core(input logic [5:0] p);
        @(posedge i_clk_sys);
        pul <= p;
        @(posedge i_clk_sys);
        pul <= 6'h00;
        if (p[5]) fl = p[4] & !p[3];
        if (p[2] | p[1]) wl = 0;
        if (p[0]) begin
            fz = 1;
            le = 0;
        end
        repeat (3) @(posedge i_clk_sys);
        sync();
    endtask : core
    task lvl(input logic g);
        @(posedge i_clk_sys);
        lv <= 5'($urandom);
        i_guard_n <= g;
        sync();
    endtask : lvl
    task rst;
        @(posedge i_clk_sys);
        i_arst_n <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        {lk, fl, wl, ae, le, fz} = '0;
        repeat (4) @(posedge i_clk_sys);
    endtask : rst
    // Main sequence.
    initial begin
        void'($urandom(25242));
        rst();
        for (int i = 0; i < 4; i++) lvl(i[0]);
        fr(16, 24'h311800);
        fr(8, 24'h060000);
        fr(16, 24'h31FF00);
        fr(8, 24'h060000);
        fr(4, 24'h010000);
        fr(12, 24'h018000);
        fr(8, 24'h060000);
        fr(24, 24'h01BC55);
        lvl(1'b0);
        fr(8, 24'h060000);
        fr(16, 24'h010000);
        fr(8, 24'h060000);
        core(6'h04);
        fr(8, 24'h060000);
        core(6'h02);
        core(6'h30);
        core(6'h38);
        core(6'h20);
        lvl(1'b1);
        fr(8, 24'h060000);
        fr(16, 24'h010000);
        fr(24, 24'hF0D000);
        fr(8, 24'h060000);
        fr(16, 24'h310800);
        fr(16, 24'hF0D000);
        fr(8, 24'h060000);
        core(6'h01);
        fr(16, 24'h311800);
        fr(8, 24'h060000);
        fr(8, 24'h040000);
        rst();
        sync();
        finish_test();
    end
endmodule : serial_flash_status_register_tb_top
`default_nettype wire
